// ==== shared/serial_pkg.sv ====
/*
 * Constants, register map and state types for the serial port block.
 * Assumes a 32-bit peripheral register bus and one system clock.
 */
// Function
// RULE1 - Frame: start, eight data bits LSB first, optional parity, one stop.
// RULE2 - Data write queues low byte; transmitter runs only when enabled.
// RULE3 - Idle after stop: line high, shifter-empty set; cleared when queued.
// RULE4 - Status shows transmit queue empty whenever it holds nothing.
// RULE5 - Disabling the transmitter aborts at once, partial character included.
// RULE6 - Software must not write data while disabled or queue full.
// RULE7 - Status shows transmit full, below-half and entry count.
// RULE8 - Falling edge, recheck at half bit, then sample each bit centre.
// RULE9 - Input filtered by eight stages; level changes only when all agree.
// RULE10 - Received bytes queue in eight entries; data read pops one.
// RULE11 - Bits assembled LSB first; data ready set while queue non-empty.
// RULE12 - Error flags set at byte end; errored frames are discarded.
// RULE13 - Error flags accumulate until software writes zeros.
// RULE14 - Start seen with queue and shifter full: drop shifter, flag overrun.
// RULE15 - Status shows receive full, at-least-half and entry count.
// RULE16 - 12-bit down-counter ticks on underflow and reloads from scaler.
// RULE17 - Software sets scaler to clock over eight times baud rate; the code ticks every scaler plus one clocks, so it needs that value minus one.
// RULE18 - Loop-back feeds transmitter to receiver, external output stays idle.
// RULE19 - Transmit pulse interrupt when enabled queue goes from data to empty.
// RULE20 - Transmit queue interrupt level while enabled and below half.
// RULE21 - Receive queue interrupt level while enabled and at least half.
// RULE22 - Receive pulse interrupt, gated by its enable and receiver enable.
package serial_pkg;

	localparam logic [31:0] ADDR_DATA    = 32'h8000_0100;
	localparam logic [31:0] ADDR_STATUS  = 32'h8000_0104;
	localparam logic [31:0] ADDR_CONTROL = 32'h8000_0108;
	localparam logic [31:0] ADDR_SCALER  = 32'h8000_010c;

	localparam int QUEUE_DEPTH = 8;
	localparam logic [3:0] QUEUE_FULL = 4'h8;
	localparam logic [3:0] QUEUE_HALF = 4'h4;
	localparam logic [2:0] TICK_LAST  = 3'h7;
	localparam logic [2:0] TICK_MID   = 3'h3;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	// Control bit positions.
	localparam int CTL_RX_EN     = 0;
	localparam int CTL_TX_EN     = 1;
	localparam int CTL_RX_IRQ    = 2;
	localparam int CTL_TX_IRQ    = 3;
	localparam int CTL_PAR_ODD   = 4;
	localparam int CTL_PAR_EN    = 5;
	localparam int CTL_LOOP      = 7;
	localparam int CTL_TX_Q_IRQ  = 9;
	localparam int CTL_RX_Q_IRQ  = 10;
	localparam int CTL_WIDTH     = 11;

	// Status bit positions.
	localparam int ST_RX_READY   = 0;
	localparam int ST_TX_SH_MT   = 1;
	localparam int ST_TX_Q_MT    = 2;
	localparam int ST_OVERRUN    = 4;
	localparam int ST_PARITY     = 5;
	localparam int ST_FRAMING    = 6;
	localparam int ST_TX_HALF    = 7;
	localparam int ST_RX_HALF    = 8;
	localparam int ST_TX_FULL    = 9;
	localparam int ST_RX_FULL    = 10;
	localparam int ST_TX_CNT     = 20;
	localparam int ST_RX_CNT     = 26;

	localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 11'h000;
	localparam logic [11:0] SCALER_RESET  = 12'h000;
	localparam logic [7:0]  FILTER_IDLE   = 8'hff;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP}
		tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
		rx_state_t;

	typedef struct packed {
		logic [CTL_WIDTH-1:0] ctrl;
		logic [11:0]          scaler;
		logic [11:0]          scnt;
		logic [7:0][7:0]      tmem;
		logic [2:0]           twp;
		logic [2:0]           trp;
		logic [3:0]           transmit_queue_count;
		logic [7:0][7:0]      rmem;
		logic [2:0]           rwp;
		logic [2:0]           rrp;
		logic [3:0]           receive_queue_count;
		logic                 sh_empty;
		logic                 overrun;
		logic                 par_err;
		logic                 frm_err;
		tx_state_t            tst;
		logic [7:0]           tsh;
		logic [2:0]           tbit;
		logic [2:0]           ttk;
		logic                 txo;
		logic                 txpin;
		logic [1:0]           sync;
		logic [7:0]           filt;
		logic                 lev;
		logic                 lev_prev;
		rx_state_t            rst;
		logic [7:0]           rsh;
		logic [2:0]           rbit;
		logic [2:0]           rtk;
		logic                 rpar;
		logic [7:0]           hold;
		logic                 holdv;
		logic [31:0]          rdata;
		logic                 ready;
		logic                 irq;
	} state_t;

endpackage : serial_pkg

// ==== hdl/serial_port.sv ====
/*
 * Serial transmitter and receiver with eight-entry queues on a
 * peripheral register bus. Assumes one system clock, an asynchronous
 * active-low reset, and a serial input that is asynchronous to the clock.
 */
`timescale 1ns/1ps
module serial_port (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// Register bus
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Serial line
	input  wire logic        i_rxd,
	output logic             o_txd,
	// Interrupt
	output logic             o_irq
);

	serial_pkg::state_t q;
	serial_pkg::state_t d;

	always_comb
	begin
		logic       tick;
		logic       take;
		logic       tpush;
		logic       tpop;
		logic       rpush;
		logic       rpop;
		logic [7:0] rbyte;
		logic       par_bad;
		logic       tx_pulse;
		logic       rx_pulse;
		logic       rdone;
		tick     = 1'b0;
		rdone    = 1'b0;
		take     = 1'b0;
		tpush    = 1'b0;
		tpop     = 1'b0;
		rpush    = 1'b0;
		rpop     = 1'b0;
		rbyte    = 8'h00;
		par_bad  = 1'b0;
		tx_pulse = 1'b0;
		rx_pulse = 1'b0;
		d        = q;

		// Scaler: underflow gives one tick at eight times the bit rate.
		if (q.scnt == 12'h000)
		begin
			tick   = 1'b1; // RULE16
			d.scnt = q.scaler; // RULE16
		end
		else
		begin
			d.scnt = q.scnt - 12'h001;
		end

		// Register bus: one wait state, so every answer comes from a flop.
		take    = i_psel & i_penable & ~q.ready;
		d.ready = take;
		d.rdata = 32'h0000_0000;
		if (take && !i_pwrite)
		begin
			case (i_paddr)
				serial_pkg::ADDR_DATA:
				begin
					d.rdata = {24'h00_0000, q.rmem[q.rrp]}; // RULE10
					rpop    = (q.receive_queue_count != 4'h0); // RULE10
				end
				serial_pkg::ADDR_STATUS:
				begin
					d.rdata[serial_pkg::ST_RX_READY] = (q.receive_queue_count != 4'h0); // RULE11
					d.rdata[serial_pkg::ST_TX_SH_MT] = q.sh_empty; // RULE3
					d.rdata[serial_pkg::ST_TX_Q_MT]  = (q.transmit_queue_count == 4'h0); // RULE4
					d.rdata[serial_pkg::ST_OVERRUN]  = q.overrun;
					d.rdata[serial_pkg::ST_PARITY]   = q.par_err;
					d.rdata[serial_pkg::ST_FRAMING]  = q.frm_err;
					d.rdata[serial_pkg::ST_TX_HALF]  =
						(q.transmit_queue_count < serial_pkg::QUEUE_HALF); // RULE7
					d.rdata[serial_pkg::ST_RX_HALF]  =
						(q.receive_queue_count >= serial_pkg::QUEUE_HALF); // RULE15
					d.rdata[serial_pkg::ST_TX_FULL]  =
						(q.transmit_queue_count == serial_pkg::QUEUE_FULL); // RULE7
					d.rdata[serial_pkg::ST_RX_FULL]  =
						(q.receive_queue_count == serial_pkg::QUEUE_FULL); // RULE15
					d.rdata[serial_pkg::ST_TX_CNT +: 4] = q.transmit_queue_count; // RULE7
					d.rdata[serial_pkg::ST_RX_CNT +: 4] = q.receive_queue_count; // RULE15
				end
				serial_pkg::ADDR_CONTROL:
					d.rdata = {21'h00_0000, q.ctrl};
				serial_pkg::ADDR_SCALER:
					d.rdata = {20'h0_0000, q.scaler};
				default:
					d.rdata = 32'h0000_0000;
			endcase
		end
		if (take && i_pwrite)
		begin
			case (i_paddr)
				serial_pkg::ADDR_DATA:
					// A write into a full queue is dropped rather than
					// overwriting the oldest entry.
					tpush = (q.transmit_queue_count != serial_pkg::QUEUE_FULL); // RULE2
				serial_pkg::ADDR_STATUS:
				begin
					// Writing zero clears a flag; set below wins.
					d.overrun = q.overrun & i_pwdata[serial_pkg::ST_OVERRUN]; // RULE13
					d.par_err = q.par_err & i_pwdata[serial_pkg::ST_PARITY]; // RULE13
					d.frm_err = q.frm_err & i_pwdata[serial_pkg::ST_FRAMING]; // RULE13
				end
				serial_pkg::ADDR_CONTROL:
					d.ctrl = i_pwdata[serial_pkg::CTL_WIDTH-1:0];
				serial_pkg::ADDR_SCALER:
					d.scaler = i_pwdata[11:0];
				default:
					d.ctrl = q.ctrl;
			endcase
		end

		// Transmitter.
		if (!q.ctrl[serial_pkg::CTL_TX_EN])
		begin
			d.tst = serial_pkg::TX_IDLE; // RULE5
			d.txo = 1'b1; // RULE5
			d.ttk = 3'h0;
			// The aborted character is gone, so the shifter reads as empty.
			d.sh_empty = 1'b1; // RULE5
		end
		else
		begin
			if (tick)
				d.ttk = q.ttk + 3'h1;
			case (q.tst)
				serial_pkg::TX_IDLE:
				begin
					d.txo = 1'b1; // RULE3
					if (q.transmit_queue_count != 4'h0)
					begin
						tpop       = 1'b1;
						d.tsh      = q.tmem[q.trp];
						d.tst      = serial_pkg::TX_START;
						d.txo      = 1'b0; // RULE1
						d.ttk      = 3'h0;
						d.tbit     = 3'h0;
						d.sh_empty = 1'b0; // RULE3
					end
					else
					begin
						d.sh_empty = 1'b1; // RULE3
					end
				end
				serial_pkg::TX_START:
					if (tick && q.ttk == serial_pkg::TICK_LAST)
					begin
						d.tst = serial_pkg::TX_DATA;
						d.txo = q.tsh[0]; // RULE1
					end
				serial_pkg::TX_DATA:
					if (tick && q.ttk == serial_pkg::TICK_LAST)
					begin
						d.tbit = q.tbit + 3'h1;
						if (q.tbit != serial_pkg::BIT_LAST)
						begin
							d.txo = q.tsh[q.tbit + 3'h1]; // RULE1
						end
						else if (q.ctrl[serial_pkg::CTL_PAR_EN])
						begin
							d.tst = serial_pkg::TX_PARITY;
							d.txo = ^q.tsh ^ q.ctrl[serial_pkg::CTL_PAR_ODD];
						end
						else
						begin
							d.tst = serial_pkg::TX_STOP;
							d.txo = 1'b1; // RULE1
						end
					end
				serial_pkg::TX_PARITY:
					if (tick && q.ttk == serial_pkg::TICK_LAST)
					begin
						d.tst = serial_pkg::TX_STOP;
						d.txo = 1'b1; // RULE1
					end
				serial_pkg::TX_STOP:
					if (tick && q.ttk == serial_pkg::TICK_LAST)
						d.tst = serial_pkg::TX_IDLE; // RULE1
				default:
					d.tst = serial_pkg::TX_IDLE;
			endcase
		end
		// Loop-back keeps the pin idle while the line goes inward.
		d.txpin = d.txo | d.ctrl[serial_pkg::CTL_LOOP]; // RULE18

		// Input path: two-flop synchroniser, then an eight-stage filter.
		d.sync = {q.sync[0], i_rxd};
		d.filt = {q.filt[6:0],
			q.ctrl[serial_pkg::CTL_LOOP] ? q.txo : q.sync[1]}; // RULE18
		if (q.filt == 8'hff)
			d.lev = 1'b1; // RULE9
		else if (q.filt == 8'h00)
			d.lev = 1'b0; // RULE9
		d.lev_prev = q.lev;

		// Receiver.
		if (!q.ctrl[serial_pkg::CTL_RX_EN])
		begin
			d.rst = serial_pkg::RX_IDLE;
		end
		else
		begin
			if (tick)
				d.rtk = q.rtk + 3'h1;
			case (q.rst)
				serial_pkg::RX_IDLE:
					if (q.lev_prev && !q.lev)
					begin
						d.rst = serial_pkg::RX_START; // RULE8
						d.rtk = 3'h0;
						if (q.holdv && !rpop
							&& q.receive_queue_count == serial_pkg::QUEUE_FULL)
						begin
							d.holdv   = 1'b0; // RULE14
							d.overrun = 1'b1; // RULE14
						end
					end
				serial_pkg::RX_START:
					if (tick && q.rtk == serial_pkg::TICK_MID)
					begin
						d.rtk  = 3'h0;
						d.rbit = 3'h0;
						d.rpar = 1'b0;
						d.rst  = q.lev ? serial_pkg::RX_IDLE
						               : serial_pkg::RX_DATA; // RULE8
					end
				serial_pkg::RX_DATA:
					if (tick && q.rtk == serial_pkg::TICK_LAST)
					begin
						d.rsh  = {q.lev, q.rsh[7:1]}; // RULE11
						d.rbit = q.rbit + 3'h1;
						if (q.rbit == serial_pkg::BIT_LAST)
							d.rst = q.ctrl[serial_pkg::CTL_PAR_EN]
								? serial_pkg::RX_PARITY
								: serial_pkg::RX_STOP; // RULE8
					end
				serial_pkg::RX_PARITY:
					if (tick && q.rtk == serial_pkg::TICK_LAST)
					begin
						d.rpar = q.lev;
						d.rst  = serial_pkg::RX_STOP;
					end
				serial_pkg::RX_STOP:
					if (tick && q.rtk == serial_pkg::TICK_LAST)
					begin
						d.rst   = serial_pkg::RX_IDLE;
						par_bad = q.ctrl[serial_pkg::CTL_PAR_EN] &
							(q.rpar != (^q.rsh ^ q.ctrl[serial_pkg::CTL_PAR_ODD]));
						if (par_bad)
							d.par_err = 1'b1; // RULE12
						if (!q.lev)
							d.frm_err = 1'b1; // RULE12
						if (!par_bad && q.lev)
						begin
							// A full queue leaves the byte in the shifter.
							d.hold  = q.rsh; // RULE12
							d.holdv = 1'b1;
							rdone   = 1'b1;
						end
					end
				default:
					d.rst = serial_pkg::RX_IDLE;
			endcase
		end

		// Held byte enters the queue as soon as there is room.
		if (q.holdv && (q.receive_queue_count != serial_pkg::QUEUE_FULL || rpop))
		begin
			rpush   = 1'b1; // RULE10
			rbyte   = q.hold;
			// A byte finished in this same cycle stays held behind it.
			d.holdv = rdone;
		end

		// Queue pointers and counts.
		if (tpush)
		begin
			d.tmem[q.twp] = i_pwdata[7:0]; // RULE2
			d.twp         = q.twp + 3'h1;
		end
		if (tpop)
			d.trp = q.trp + 3'h1;
		d.transmit_queue_count = q.transmit_queue_count + {3'h0, tpush} - {3'h0, tpop};
		if (rpush)
		begin
			d.rmem[q.rwp] = rbyte; // RULE10
			d.rwp         = q.rwp + 3'h1;
		end
		if (rpop)
			d.rrp = q.rrp + 3'h1;
		d.receive_queue_count = q.receive_queue_count + {3'h0, rpush} - {3'h0, rpop};

		// Interrupt: two pulse events and two queue levels.
		tx_pulse = q.ctrl[serial_pkg::CTL_TX_IRQ] & q.ctrl[serial_pkg::CTL_TX_EN]
			& (q.transmit_queue_count != 4'h0) & (d.transmit_queue_count == 4'h0); // RULE19
		rx_pulse = q.ctrl[serial_pkg::CTL_RX_IRQ] & q.ctrl[serial_pkg::CTL_RX_EN]
			& rpush; // RULE22
		d.irq = tx_pulse | rx_pulse
			| (q.ctrl[serial_pkg::CTL_TX_Q_IRQ] & q.ctrl[serial_pkg::CTL_TX_EN]
			& (d.transmit_queue_count < serial_pkg::QUEUE_HALF)) // RULE20
			| (q.ctrl[serial_pkg::CTL_RX_Q_IRQ] & q.ctrl[serial_pkg::CTL_RX_EN]
			& (d.receive_queue_count >= serial_pkg::QUEUE_HALF)); // RULE21
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			q          <= '0;
			q.ctrl     <= serial_pkg::CONTROL_RESET;
			q.scaler   <= serial_pkg::SCALER_RESET;
			q.sh_empty <= 1'b1;
			q.tst      <= serial_pkg::TX_IDLE;
			q.txo      <= 1'b1;
			q.txpin    <= 1'b1;
			q.sync     <= 2'h3;
			q.filt     <= serial_pkg::FILTER_IDLE;
			q.lev      <= 1'b1;
			q.lev_prev <= 1'b1;
			q.rst      <= serial_pkg::RX_IDLE;
		end
		else
		begin
			q <= d;
		end
	end

	assign o_prdata  = q.rdata;
	assign o_pready  = q.ready;
	assign o_pslverr = 1'b0;
	assign o_txd     = q.txpin;
	assign o_irq     = q.irq;

endmodule : serial_port

// ==== sim/serial_port_asserts.sv ====
/* Assertions on the serial port's bus, line and interrupt ports.
 * Assumes it is bound to serial_port and sees only its ports. */
`timescale 1ns/1ps
module serial_port_asserts (
	// Clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rstn,
	// Register bus
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	// Line and interrupt
	input wire logic        o_txd,
	input wire logic        o_irq
);
	// Control as the bus wrote it; it lags the block's copy by a cycle,
	// so the a_tx_off and a_irq_off checks built on it allow one extra cycle; a_loop does not.
	logic [10:0] ctl_q;
	logic        irq_off;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	assign irq_off = ctl_q[10:9] == 2'h0 && ctl_q[3:2] == 2'h0;

	always_ff @(posedge i_core_clk or negedge i_rstn)
		if (!i_rstn)
			ctl_q <= 11'h000;
		else if (i_psel && i_penable && i_pwrite && o_pready &&
			i_paddr == serial_pkg::ADDR_CONTROL)
			ctl_q <= i_pwdata[10:0];

	property p_answer; i_psel && i_penable && !o_pready |=> o_pready;
	endproperty
	property p_ready_pulse; o_pready |=> !o_pready; endproperty
	property p_idle_data; !o_pready |-> o_prdata == 32'h0; endproperty
	property p_start; $fell(o_txd) |-> !o_txd [*8]; endproperty
	property p_high_bit; $rose(o_txd) |-> o_txd [*8]; endproperty
	property p_tx_off; !ctl_q[1] [*2] |-> o_txd; endproperty
	property p_loop; ctl_q[7] |-> o_txd; endproperty
	property p_irq_off; irq_off [*2] |-> !o_irq; endproperty

	a_answer: assert property (p_answer) else $error("no answer");
	a_ready_pulse: assert property (p_ready_pulse) else $error("long");
	a_idle_data: assert property (p_idle_data) else $error("data");
	a_start: assert property (p_start) else $error("short start");
	a_high_bit: assert property (p_high_bit) else $error("short bit");
	a_tx_off: assert property (p_tx_off) else $error("line active");
	a_loop: assert property (p_loop) else $error("line in loop");
	a_irq_off: assert property (p_irq_off) else $error("irq");

	c_frame: cover property ($fell(o_txd));
	c_irq: cover property ($rose(o_irq));
	c_loop: cover property (ctl_q[7] && o_pready);
endmodule : serial_port_asserts

bind serial_port serial_port_asserts serial_port_asserts_inst (
	.i_core_clk (i_core_clk),
	.i_rstn     (i_rstn),
	.i_psel     (i_psel),
	.i_penable  (i_penable),
	.i_pwrite   (i_pwrite),
	.i_paddr    (i_paddr),
	.i_pwdata   (i_pwdata),
	.o_prdata   (o_prdata),
	.o_pready   (o_pready),
	.o_txd      (o_txd),
	.o_irq      (o_irq)
);

// ==== sim/serial_peer.sv ====
/* Remote serial peer: sends frames into the block, records its frames.
 * Assumes an idle-high line and the scaler the bench programs. */
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_NS = 80
) (
	// Line from the block
	input  wire logic i_line,
	// Line into the block
	output logic      o_line
);
	logic [7:0] got[$];
	logic       par_en = 1'b0;
	logic [7:0] b;

	initial o_line = 1'b1;

	task send(input logic [7:0] d, input logic bad_par, bad_stop);
		int i;
		o_line = 1'b0;
		#(BIT_NS);
		for (i = 0; i < 8; i++)
		begin
			o_line = d[i];
			#(BIT_NS);
		end
		if (par_en)
		begin
			o_line = ^d ^ bad_par;
			#(BIT_NS);
		end
		o_line = !bad_stop;
		#(BIT_NS);
		o_line = 1'b1;
		#(BIT_NS);
	endtask : send

	// Far shorter than the block's input filter, so it must vanish.
	task glitch;
		o_line = 1'b0;
		#15;
		o_line = 1'b1;
		#(BIT_NS);
	endtask : glitch

	always
	begin : rx_loop
		int i;
		@(negedge i_line);
		#(BIT_NS / 2);
		if (!i_line)
		begin
			for (i = 0; i < 8; i++)
			begin
				#(BIT_NS);
				b[i] = i_line;
			end
			if (par_en)
				#(BIT_NS);
			#(BIT_NS);
			if (i_line)
				got.push_back(b);
		end
	end
endmodule : serial_peer

// ==== sim/test_serial_port.sv ====
/* Self-checking bench for the serial port and its remote peer.
 * Assumes the scaler is set to 1, so one bit lasts 80 ns. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	error_cnt++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
	end end
module test_serial_port;
	localparam logic [31:0] DAT = serial_pkg::ADDR_DATA;
	localparam logic [31:0] STA = serial_pkg::ADDR_STATUS;
	localparam logic [31:0] CTL = serial_pkg::ADDR_CONTROL;
	logic        i_core_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [31:0] i_paddr = 32'h0;
	logic [31:0] i_pwdata = 32'h0;
	logic [31:0] o_prdata;
	logic [31:0] r;
	logic        o_pready;
	logic        o_txd;
	logic        o_irq;
	logic        i_rxd;
	logic        irq_seen = 1'b0;
	int          error_cnt = 0;
	int          n_compared = 0;

	always #2.5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk)
		if (o_irq === 1'b1)
			irq_seen <= 1'b1;

	serial_port serial_port_inst (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_psel     (i_psel),
		.i_penable  (i_penable),
		.i_pwrite   (i_pwrite),
		.i_paddr    (i_paddr),
		.i_pwdata   (i_pwdata),
		.o_prdata   (o_prdata),
		.o_pready   (o_pready),
		.o_pslverr  (),
		.i_rxd      (i_rxd),
		.o_txd      (o_txd),
		.o_irq      (o_irq)
	);
	serial_peer #(.BIT_NS(80)) peer (.i_line(o_txd), .o_line(i_rxd));

	// Holds the request until the edge after ready is seen high.
	task acc(input logic w, input logic [31:0] a, d);
		int n;
		@(posedge i_core_clk);
		#1 i_psel = 1'b1;
		i_pwrite = w;
		i_paddr = a;
		i_pwdata = d;
		@(posedge i_core_clk);
		#1 i_penable = 1'b1;
		n = 0;
		do
		begin
			@(posedge i_core_clk);
			#1 n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		r = o_prdata;
		@(posedge i_core_clk);
		#1 i_psel = 1'b0;
		i_penable = 1'b0;
	endtask : acc

	task wr(input logic [31:0] a, d);
		acc(1'b1, a, d);
	endtask : wr

	task rd(input logic [31:0] a);
		acc(1'b0, a, 32'h0);
	endtask : rd

	task report_and_stop;
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task t_regs;
		rd(STA);
		`CHK(r, 32'h0000_0086);
		rd(CTL);
		`CHK(r, 32'h0000_0000);
		rd(32'h8000_0110);
		`CHK(r, 32'h0000_0000);
		wr(serial_pkg::ADDR_SCALER, 32'hffff_f001);
		rd(serial_pkg::ADDR_SCALER);
		`CHK(r, 32'h0000_0001);
	endtask : t_regs

	// Nine writes with the transmitter running: the first moves to the
	// shifter at once, the other eight fill the queue without overflow.
	task t_tx;
		int i;
		wr(CTL, 32'h0000_000a);
		for (i = 1; i <= 9; i++)
			wr(DAT, 32'(i));
		rd(STA);
		`CHK(r, 32'h0080_0200);
		for (i = 0; i < 8000 && peer.got.size() < 9; i++)
			@(posedge i_core_clk);
		repeat (40) @(posedge i_core_clk);
		for (i = 0; i < 9; i++)
			`CHK(peer.got[i], 8'(i + 1));
		`CHK(peer.got.size(), 9);
		rd(STA);
		`CHK(r, 32'h0000_0086);
		`CHK(irq_seen, 1'b1);
		wr(CTL, 32'h0000_0202);
		`CHK(o_irq, 1'b1);
		wr(CTL, 32'h0);
		`CHK(o_irq, 1'b0);
	endtask : t_tx

	task t_abort;
		int bad;
		wr(CTL, 32'h0000_0002);
		wr(DAT, 32'h0);
		repeat (40) @(posedge i_core_clk);
		#1 `CHK(o_txd, 1'b0);
		wr(CTL, 32'h0);
		bad = 0;
		repeat (200)
		begin
			@(posedge i_core_clk);
			#1 bad += (o_txd !== 1'b1);
		end
		`CHK(bad, 0);
		peer.got.delete();
	endtask : t_abort

	task t_rx;
		int i;
		peer.par_en = 1'b1;
		wr(CTL, 32'h0000_0421);
		peer.glitch();
		for (i = 0; i < 4; i++)
			peer.send(8'hc3 + 8'(i), 1'b0, 1'b0);
		rd(STA);
		`CHK(r, 32'h1000_0187);
		`CHK(o_irq, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			rd(DAT);
			`CHK(r[7:0], 8'hc3 + 8'(i));
		end
		rd(STA);
		`CHK(r, 32'h0000_0086);
	endtask : t_rx

	task t_err;
		peer.send(8'h55, 1'b1, 1'b0);
		rd(STA);
		`CHK(r, 32'h0000_00a6);
		peer.send(8'h55, 1'b0, 1'b1);
		rd(STA);
		`CHK(r, 32'h0000_00e6);
		wr(STA, 32'h0);
		rd(STA);
		`CHK(r, 32'h0000_0086);
	endtask : t_err

	// Ten frames: the ninth waits in the shifter and the tenth drops it.
	task t_over;
		int i;
		for (i = 0; i < 10; i++)
			peer.send(8'h10 + 8'(i), 1'b0, 1'b0);
		rd(STA);
		`CHK(r, 32'h2000_0597);
		for (i = 0; i < 9; i++)
		begin
			rd(DAT);
			`CHK(r[7:0], 8'h10 + 8'(i < 8 ? i : 9));
		end
		wr(STA, 32'h0);
	endtask : t_over

	task t_loop;
		int k;
		peer.par_en = 1'b0;
		wr(CTL, 32'h0000_0083);
		wr(DAT, 32'h0000_005a);
		r = 32'h0;
		for (k = 0; k < 100 && r[0] !== 1'b1; k++)
			rd(STA);
		rd(DAT);
		`CHK(r[7:0], 8'h5a);
		`CHK(peer.got.size(), 0);
	endtask : t_loop

	initial
	begin
		repeat (8) @(posedge i_core_clk);
		#1 i_rstn = 1'b1;
		t_regs();
		t_tx();
		t_abort();
		t_rx();
		t_err();
		t_over();
		t_loop();
		report_and_stop();
	end

	initial
	begin
		#300000;
		error_cnt++;
		report_and_stop();
	end
endmodule : test_serial_port
